// ### hw/scr_top.sv
// scr_top: sample capture ram with fifo, two bank pairs, controller
// assumes synchronous inputs, filter valid pulse per sample, host bus read only when idle
`timescale 1ns/1ps
`default_nettype none
`include "scr_defines.svh"

module scr_fifo #(
  parameter int W = 64,
  parameter int D = `SCR_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0]   cnt_r;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;
  assign in_ready  = cnt_r != (AW+1)'(D);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rp_r];
  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= in_data;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      if (pop)  rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // scr_fifo

module scr_top
  import scr_pkg::*;
#(
  parameter int AW = `SCR_ADDR_W,
  parameter int CW = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // filter side
  input  wire logic              flt_valid,
  output logic                   flt_ready,
  input  wire scr_pkg::scr_cplx_t ch1_in,
  input  wire scr_pkg::scr_cplx_t ch2_in,
  // measurement setup
  input  wire logic              two_ch,
  input  wire logic              act_ch2,
  input  wire logic              zoom,
  input  wire logic              diag,
  input  wire logic              start,
  input  wire logic              trig,
  input  wire logic              wrap_en,
  input  wire logic [AW-1:0]     blk_len,
  input  wire logic [CW-1:0]     pre_cnt,
  input  wire logic [CW-1:0]     post_cnt,
  // system bus
  input  wire logic              sys_rd,
  input  wire logic              sys_wr,
  input  wire logic              sys_bank,
  input  wire logic [AW-1:0]     sys_addr,
  input  wire logic [2*`SCR_SAMPLE_W-1:0] sys_d_in,
  output logic [2*`SCR_SAMPLE_W-1:0]      sys_d_out,
  output logic                   sys_d_oe,
  // status
  output logic                   busy,
  output logic                   done
);
  import scr_pkg::*;
  localparam int SW = `SCR_SAMPLE_W;
  // 2**16 words x 2 bank pairs x 32b = 512 kB standard; expanded build widens AW
  localparam int DEPTH = 1 << AW;
  scr_cplx_t   bank1 [DEPTH];
  scr_cplx_t   bank2 [DEPTH];
  scr_pair_t   fifo_out, lat_nxt, wdat_r;
  logic          wr_r, b1w_r;
  scr_state_t  st_r, st_nxt;
  logic [AW-1:0] agen_r, alat_r;
  logic          b1sel_r, full_r, done_r;
  logic [CW-1:0] tc1_r, tc2_r;
  logic          f_valid, f_ready, wr_en, fill_pt, at_end;
  logic [2*SW-1:0] rd_r;
  logic            oe_r;

  // imaginary words only meaningful in zoom, zeroed otherwise
  wire scr_cplx_t s1 = '{re: ch1_in.re, im: zoom ? ch1_in.im : '0};
  wire scr_cplx_t s2 = '{re: ch2_in.re, im: zoom ? ch2_in.im : '0};
  wire scr_cplx_t act = act_ch2 ? s2 : s1;
  wire scr_cplx_t dg  = '{re: sys_d_in[2*SW-1:SW], im: sys_d_in[SW-1:0]};
  wire           diag_wr = diag && sys_wr;
  always_comb begin
    lat_nxt.a = s1;
    lat_nxt.b = two_ch ? s2 : act;
    if (diag_wr) lat_nxt = '{a: dg, b: dg};
  end

  wire capturing = (st_r == SCR_PRE) || (st_r == SCR_ARMED) || (st_r == SCR_POST);
  scr_fifo #(.W($bits(scr_pair_t)), .D(`SCR_FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .in_valid ((flt_valid && capturing) || diag_wr),
    .in_ready (flt_ready),
    .in_data  (lat_nxt),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data (fifo_out)
  );

  // write drains fifo; bank reads by host stall it
  assign f_ready = !full_r && !sys_rd;
  assign wr_en   = f_valid && f_ready;
  assign at_end  = agen_r == blk_len;
  assign fill_pt = wr_en && at_end;

  // bank writes see only the latched address, so writes trail the generator by one cycle
  always_ff @(posedge clk) begin
    if (wr_r) begin
      if (two_ch) begin
        bank1[alat_r] <= wdat_r.a;
        bank2[alat_r] <= wdat_r.b;
      end else if (b1w_r && !act_ch2) begin
        bank1[alat_r] <= wdat_r.b;
      end else if (!b1w_r) begin
        bank2[alat_r] <= wdat_r.b;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      agen_r  <= '0;
      b1sel_r <= 1'b0;
      full_r  <= 1'b0;
    end else if (st_r == SCR_IDLE && start) begin
      agen_r  <= '0;
      b1sel_r <= 1'b0;
      full_r  <= 1'b0;
    end else if (wr_en) begin
      if (!at_end) agen_r <= agen_r + 1'b1;
      else if (!two_ch && !act_ch2 && !b1sel_r) begin
        agen_r  <= '0;
        b1sel_r <= 1'b1;
      end else if (wrap_en && st_r != SCR_POST) agen_r <= '0;
      else full_r <= 1'b1;
    end
  end

  // bank select travels with the address, chaining flips it at the same edge
  always_ff @(posedge clk) begin
    if (rst) begin
      alat_r <= '0;
      wr_r   <= 1'b0;
      b1w_r  <= 1'b0;
      wdat_r <= '0;
    end else begin
      alat_r <= agen_r;
      wr_r   <= wr_en;
      b1w_r  <= b1sel_r;
      wdat_r <= fifo_out;
    end
  end

  // controller sequencing
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SCR_IDLE:   if (start) st_nxt = SCR_SETTLE;
      SCR_SETTLE: if (tc1_r == '0) st_nxt = SCR_PRE;
      SCR_PRE:    if (tc1_r == '0) st_nxt = SCR_ARMED;
      SCR_ARMED:  if (trig) st_nxt = SCR_POST;
                  else if (full_r) st_nxt = SCR_IDLE;
      SCR_POST:   if (tc2_r == '0 || full_r) st_nxt = SCR_IDLE;
      default:    st_nxt = SCR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r   <= SCR_IDLE;
      tc1_r  <= '0;
      tc2_r  <= '0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r == SCR_IDLE && start) begin
        tc1_r  <= CW'(`SCR_SETTLE_CYC);
        done_r <= 1'b0;
      end else if (st_r == SCR_SETTLE && tc1_r == '0) tc1_r <= pre_cnt;
      else if (tc1_r != '0) tc1_r <= tc1_r - 1'b1;
      if (st_r == SCR_ARMED && trig) tc2_r <= post_cnt;
      else if (st_r == SCR_POST && wr_en && tc2_r != '0) tc2_r <= tc2_r - 1'b1;
      if ((st_r == SCR_POST || st_r == SCR_ARMED) && st_nxt == SCR_IDLE) done_r <= 1'b1;
    end
  end

  // readout through transceivers
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_r <= '0;
      oe_r <= 1'b0;
    end else begin
      oe_r <= sys_rd && !diag_wr;
      if (sys_rd) rd_r <= sys_bank ? bank2[sys_addr] : bank1[sys_addr];
    end
  end
  assign sys_d_out = rd_r;
  assign sys_d_oe  = oe_r;
  assign busy      = st_r != SCR_IDLE;
  assign done      = done_r;

  property p_addr_latch;
    @(posedge clk) disable iff (rst) 1'b1 |=> alat_r == $past(agen_r);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address latch lags wrong");

  property p_adv;
    @(posedge clk) disable iff (rst)
      (wr_en && !at_end && !(st_r == SCR_IDLE && start)) |=> agen_r == $past(agen_r) + 1'b1;
  endproperty
  a_adv: assert property (p_adv) else $error("address did not advance");

  property p_no_cap_idle;
    @(posedge clk) disable iff (rst) (st_r == SCR_IDLE && !diag_wr) |-> !u_fifo.push;
  endproperty
  a_no_cap_idle: assert property (p_no_cap_idle) else $error("capture outside acquisition");

  property p_ch2_b1;
    @(posedge clk) disable iff (rst) (!two_ch && act_ch2) |-> !b1sel_r || $past(two_ch) || !$past(act_ch2);
  endproperty
  a_ch2_b1: assert property (p_ch2_b1) else $error("bank1 used on channel 2");

  property p_chain;
    @(posedge clk) disable iff (rst) $rose(b1sel_r) |-> $past(fill_pt);
  endproperty
  a_chain: assert property (p_chain) else $error("bank1 chained early");

  property p_settle;
    @(posedge clk) disable iff (rst) (st_r == SCR_IDLE && start) |=> st_r == SCR_SETTLE ##1 st_r == SCR_SETTLE;
  endproperty
  a_settle: assert property (p_settle) else $error("settling skipped");

  property p_oe;
    @(posedge clk) disable iff (rst) (sys_rd && !diag_wr) |=> sys_d_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("readout not driven");

  property p_lat1;
    @(posedge clk) disable iff (rst) !diag_wr |-> lat_nxt.a.re == ch1_in.re;
  endproperty
  a_lat1: assert property (p_lat1) else $error("channel 1 latch wrong");
endmodule // scr_top
`default_nettype wire

// ### shared/scr_defines.svh
// scr_defines.svh: constants for the sample capture ram block
// assumes inclusion by the package, the design file and the testbench
// Operation
// - Storage is 512 kilobytes in the standard build and 8.192 megabytes in the expanded build.
// - The first latch pair captures channel 1 real and imaginary words from the filter.
// - The second latch pair captures channel 2 in two-channel mode, else the active channel.
// - The second bank pair stores channel 2 in two-channel mode, else the active channel.
// - The first bank pair stores channel 1 in two-channel mode, and in single mode on channel 1 only after the second pair fills.
// - In single mode on channel 2 the first bank pair stays unused and all samples go to the second.
// - Addresses are generated inside and held in an address latch that drives the banks; host reads address the banks from sys_addr directly.
// - Data passes from the sample lines to the system lines through transceivers, reversed in diagnostics.
// - Two trigger counters time settling, pre-trigger and post-trigger; the address generator ends the block at blk_len.
// - A controller answers system bus accesses and sequences latches, addresses, writes and transceivers.
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH
`define SCR_STD_BYTES   32'h0008_0000
`define SCR_EXP_BYTES   32'h007D_0000
`define SCR_SAMPLE_W    16
`define SCR_ADDR_W      16
`define SCR_FIFO_DEPTH  8
`define SCR_SETTLE_CYC  16'h0010
`endif

// ### shared/scr_pkg.sv
// scr_pkg: types for the sample capture ram block
// assumes scr_defines.svh sits beside it
`include "scr_defines.svh"
package scr_pkg;
  typedef struct packed {
    logic [`SCR_SAMPLE_W-1:0] re;
    logic [`SCR_SAMPLE_W-1:0] im;
  } scr_cplx_t;
  typedef struct packed {
    scr_cplx_t a;
    scr_cplx_t b;
  } scr_pair_t;
  typedef enum logic [4:0] {
    SCR_IDLE   = 5'b00001,
    SCR_SETTLE = 5'b00010,
    SCR_PRE    = 5'b00100,
    SCR_ARMED  = 5'b01000,
    SCR_POST   = 5'b10000
  } scr_state_t;
endpackage

// ### test/scr_flt_model.sv
// scr_flt_model: behavioural upstream filter that feeds the capture block
// assumes a bench task calls send once per sample, on the block clock
`timescale 1ns/1ps
`default_nettype none
module scr_flt_model
  import scr_pkg::*;
(
  // clock
  input  wire logic          clk,
  // flow control from the block
  input  wire logic          flt_ready,
  // sample outputs
  output var logic           flt_valid,
  output var scr_pkg::scr_cplx_t ch1_in,
  output var scr_pkg::scr_cplx_t ch2_in
);
  initial begin
    flt_valid = 1'b0;
    ch1_in = '0;
    ch2_in = '0;
  end
  // words mean nothing outside valid, so they are scrambled afterwards
  task automatic send(input scr_cplx_t a, input scr_cplx_t b);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    flt_valid = 1'b1;
    ch1_in = a;
    ch2_in = b;
    @(posedge clk);
    while (flt_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    #1;
    flt_valid = 1'b0;
    ch1_in = ~a;
    ch2_in = ~b;
  endtask
endmodule // scr_flt_model
`default_nettype wire

// ### test/sample_capture_ram_tb.sv
// sample_capture_ram_tb: runs capture in each channel mode, reads banks back
// assumes scr_top and scr_flt_model compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "scr_defines.svh"
module sample_capture_ram_tb;
  import scr_pkg::*;
  localparam int AW = `SCR_ADDR_W;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            two_ch = 1'b0, act_ch2 = 1'b0, zoom = 1'b0;
  logic            start = 1'b0, trig = 1'b0, sys_rd = 1'b0, sys_bank = 1'b0;
  logic [AW-1:0]   blk_len = '0, sys_addr = '0;
  logic [15:0]     pre_cnt = 16'h0002, post_cnt = 16'h0001;
  logic            flt_valid, flt_ready, sys_d_oe, busy, done;
  scr_cplx_t       ch1_in, ch2_in;
  logic [2*`SCR_SAMPLE_W-1:0] sys_d_out;
  logic [2*`SCR_SAMPLE_W-1:0] sys_d_in = 32'h0000_0000;
  logic            diag = 1'b0, sys_wr = 1'b0;
  int              fails = 0;
  int              checks_done = 0;
  scr_cplx_t       exp_q[$];
  logic            rb_q[$];
  logic [AW-1:0]   ra_q[$];
  scr_cplx_t       rv_q[$];

  scr_top #(.AW(AW), .CW(16)) i_scr_top (
    .clk(clk), .rst(rst), .flt_valid(flt_valid), .flt_ready(flt_ready),
    .ch1_in(ch1_in), .ch2_in(ch2_in), .two_ch(two_ch), .act_ch2(act_ch2),
    .zoom(zoom), .diag(diag), .start(start), .trig(trig), .wrap_en(1'b0),
    .blk_len(blk_len), .pre_cnt(pre_cnt), .post_cnt(post_cnt),
    .sys_rd(sys_rd), .sys_wr(sys_wr), .sys_bank(sys_bank), .sys_addr(sys_addr),
    .sys_d_in(sys_d_in), .sys_d_out(sys_d_out), .sys_d_oe(sys_d_oe),
    .busy(busy), .done(done));

  scr_flt_model i_scr_flt_model (
    .clk(clk), .flt_ready(flt_ready), .flt_valid(flt_valid),
    .ch1_in(ch1_in), .ch2_in(ch2_in));

  always #5 clk = ~clk;

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic complete_run();
    cmp(32'h0000_0000, 32'(exp_q.size()));
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // read data lands one cycle after the request, checked mid-cycle
  always @(negedge clk) begin
    if (sys_d_oe === 1'b1) begin
      cmp(exp_q.size() > 0 ? exp_q.pop_front() : ~sys_d_out, sys_d_out);
    end
  end

  function automatic scr_cplx_t rnd();
    return scr_cplx_t'($urandom);
  endfunction

  function automatic scr_cplx_t fix(input scr_cplx_t c, input logic z);
    fix = c;
    if (!z) fix.im = 16'h0000;
  endfunction

  task automatic note(input logic b, input int a, input scr_cplx_t v);
    rb_q.push_back(b);
    ra_q.push_back(a[AW-1:0]);
    rv_q.push_back(v);
  endtask

  task automatic rd(input logic b, input logic [AW-1:0] a, input scr_cplx_t e);
    @(posedge clk);
    #1;
    sys_rd = 1'b1;
    sys_bank = b;
    sys_addr = a;
    exp_q.push_back(e);
    @(posedge clk);
    #1;
    sys_rd = 1'b0;
  endtask

  // a bus word pushed backwards through the sample path lands in both banks
  task automatic diag_run();
    scr_cplx_t v;
    v = rnd();
    @(posedge clk);
    #1;
    two_ch = 1'b1;
    blk_len = '1;
    diag = 1'b1;
    sys_wr = 1'b1;
    sys_d_in = v;
    @(posedge clk);
    #1;
    diag = 1'b0;
    sys_wr = 1'b0;
    repeat (3) @(posedge clk);
    rd(1'b0, '0, v);
    rd(1'b1, '0, v);
  endtask

  task automatic run(input logic two, input logic a2, input logic z, input int bl, input int n);
    scr_cplx_t c1;
    scr_cplx_t c2;
    int k;
    @(posedge clk);
    #1;
    two_ch = two;
    act_ch2 = a2;
    zoom = z;
    blk_len = bl[AW-1:0];
    post_cnt = n[15:0];
    // a sample while idle must leave no trace in either bank
    i_scr_flt_model.send(rnd(), rnd());
    @(posedge clk);
    #1;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    repeat (30) @(posedge clk);
    #1;
    trig = 1'b1;
    @(posedge clk);
    #1;
    trig = 1'b0;
    for (k = 0; k < n; k++) begin
      c1 = rnd();
      c2 = rnd();
      i_scr_flt_model.send(c1, c2);
      if (two) begin
        note(1'b0, k, fix(c1, z));
        note(1'b1, k, fix(c2, z));
      end
      else if (a2) note(1'b1, k, fix(c2, z));
      else if (k <= bl) note(1'b1, k, fix(c1, z));
      else note(1'b0, k - bl - 1, fix(c1, z));
    end
    k = 0;
    while (done !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    #1;
    cmp(32'h0000_0001, {30'h0000_0000, busy, done});
    while (rb_q.size() > 0) rd(rb_q.pop_front(), ra_q.pop_front(), rv_q.pop_front());
    repeat (3) @(posedge clk);
  endtask

  initial begin
    #100000;
    fails++;
    complete_run();
  end

  initial begin
    void'($urandom(32'hd585));
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    diag_run();
    run(1'b1, 1'b0, 1'b1, 16, 4);
    run(1'b0, 1'b1, 1'b0, 16, 3);
    run(1'b0, 1'b0, 1'b1, 1, 3);
    complete_run();
  end
endmodule // sample_capture_ram_tb
`default_nettype wire
